// *** design/counter_scope.sv ***
/*
 * per-counter scope decode: which event counters see the
 * global enable, the long-counter select and a clear request.
 * assumes partition_limit is already resolved by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module counter_scope #(
    parameter int NUM_CTRS = 6
) (
    input wire logic [perf_mon_pkg::HPMN_W-1:0] partition_limit,
    input wire logic global_enable,
    input wire logic long_counter_select,
    input wire logic hyp_long_counter_select,
    input wire logic upper_global_enable,
    input wire logic restrict_clear,
    input wire logic [NUM_CTRS-1:0] counter_enable_set,
    output logic [NUM_CTRS-1:0] count_en,
    output logic [NUM_CTRS-1:0] long_mode,
    output logic [NUM_CTRS-1:0] clear_mask
);

    // -------------------------------------------------------
    // split counters at the partition limit
    // -------------------------------------------------------
    // counters at or above the limit belong to the hypervisor
    always_comb
    begin
        count_en = '0;
        long_mode = '0;
        clear_mask = '0;
        for (int i = 0; i < NUM_CTRS; i++)
        begin
            if (perf_mon_pkg::HPMN_W'(i) < partition_limit)
            begin
                count_en[i] = global_enable && counter_enable_set[i];
                long_mode[i] = long_counter_select;
                clear_mask[i] = 1'b1;
            end
            else
            begin
                // upper range ignores both control bits
                count_en[i] = upper_global_enable && counter_enable_set[i];
                long_mode[i] = hyp_long_counter_select;
                clear_mask[i] = !restrict_clear;
            end
        end
    end

endmodule // counter_scope

`default_nettype wire

// *** design/perf_mon_pkg.sv ***
/*
 * constants, field positions and carriers shared by the
 * performance-monitor identification and control registers.
 * assumes a core-side system-register access port that carries
 * the current exception level with each request.
 */
`default_nettype none

package perf_mon_pkg;

    // -------------------------------------------------------
    // exception levels and register selects
    // -------------------------------------------------------
    localparam logic [1:0] EL_USER = 2'h0;
    localparam logic [1:0] EL_KERNEL = 2'h1;
    localparam logic [1:0] EL_HYP = 2'h2;
    localparam logic [1:0] EL_MON = 2'h3;
    localparam logic SEL_MACHINE_INFO = 1'b0;
    localparam logic SEL_CONTROL = 1'b1;

    // syndrome class for a trapped system-register access
    localparam logic [5:0] SYN_SYSREG = 6'h18;

    // -------------------------------------------------------
    // perf_machine_info fields
    // -------------------------------------------------------
    localparam logic [7:0] STALL_SLOT_WIDTH = 8'h08;
    localparam int STALL_SLOT_WIDTH_LSB = 0;
    localparam int STALL_SLOT_WIDTH_MSB = 7;

    // -------------------------------------------------------
    // perf_control fields and reset values
    // -------------------------------------------------------
    localparam int CTL_E = 0;
    localparam int CTL_P = 1;
    localparam int CTL_C = 2;
    localparam int CTL_DP = 5;
    localparam int CTL_ONE = 6;
    localparam int CTL_LP = 7;
    localparam int CTL_N_LSB = 11;
    localparam int CTL_N_MSB = 15;
    localparam int CTL_IMP_LSB = 24;
    localparam int CTL_IMP_MSB = 31;
    localparam logic [7:0] IMPLEMENTER_CODE = 8'h00;
    localparam logic RST_E = 1'b0;
    localparam logic RST_DP = 1'b0;
    localparam logic RST_LP = 1'b0;
    localparam int HPMN_W = 5;

    // -------------------------------------------------------
    // carriers
    // -------------------------------------------------------
    typedef enum logic [1:0] {
        RSP_DATA = 2'b00,
        RSP_UNDEF = 2'b01,
        RSP_TRAP = 2'b10
    } rsp_kind_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic sel;
        logic [1:0] el;
        logic [63:0] wdata;
    } sysreg_req_s;

    typedef struct packed {
        logic el2_impl;
        logic el2_enabled;
        logic fine_grain_trap_enable;
        logic fine_grain_read_trap;
        logic hyp_perf_trap;
        logic monitor_perf_trap;
        logic [HPMN_W-1:0] hyp_counter_partition;
    } trap_cfg_s;

    typedef struct packed {
        logic valid;
        rsp_kind_e kind;
        logic [1:0] target_el;
        logic [5:0] syndrome;
        logic [63:0] rdata;
    } sysreg_rsp_s;

endpackage

`default_nettype wire

// *** design/perf_monitor_control_regs.sv ***
/*
 * machine-identification and control registers of the
 * performance monitor, with read trapping of the former.
 * assumes one request per cycle from the core's system-register
 * port; the counters themselves live outside and obey the
 * enable, long-mode and clear outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module perf_monitor_control_regs #(
    parameter int NUM_CTRS = 6
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire perf_mon_pkg::sysreg_req_s req,
    input wire perf_mon_pkg::trap_cfg_s trap_cfg,
    input wire logic hyp_long_counter_select,
    input wire logic upper_global_enable,
    input wire logic [NUM_CTRS-1:0] counter_enable_set,
    input wire logic cycle_enable_set,
    input wire logic counting_prohibited,
    output perf_mon_pkg::sysreg_rsp_s rsp,
    output logic [NUM_CTRS-1:0] evt_count_en,
    output logic [NUM_CTRS-1:0] evt_long_mode,
    output logic [NUM_CTRS-1:0] evt_clear,
    output logic cyc_count_en,
    output logic cyc_clear
);

    // -------------------------------------------------------
    // build checks
    // -------------------------------------------------------
    // only the two documented counter builds are served
    generate
        if (NUM_CTRS != 6 && NUM_CTRS != 20)
        begin : g_bad_count
            $error("NUM_CTRS must be 6 or 20");
        end
    endgenerate

    localparam logic [perf_mon_pkg::HPMN_W-1:0] N_FIELD =
        perf_mon_pkg::HPMN_W'(NUM_CTRS);

    // -------------------------------------------------------
    // state
    // -------------------------------------------------------
    typedef struct packed {
        logic lp;
        logic dp;
        logic e;
        perf_mon_pkg::sysreg_rsp_s rsp;
        logic [NUM_CTRS-1:0] evt_en;
        logic [NUM_CTRS-1:0] evt_long;
        logic [NUM_CTRS-1:0] evt_clr;
        logic cyc_en;
        logic cyc_clr;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic [perf_mon_pkg::HPMN_W-1:0] partition_limit;
    logic restrict_clear;
    logic [NUM_CTRS-1:0] scope_en;
    logic [NUM_CTRS-1:0] scope_long;
    logic [NUM_CTRS-1:0] scope_clr;

    // -------------------------------------------------------
    // helpers
    // -------------------------------------------------------
    // read image of the control register
    function automatic logic [63:0] ctl_image(
        input logic lp,
        input logic dp,
        input logic e
    );
        logic [63:0] v;
        v = 64'h0000_0000_0000_0000;
        v[perf_mon_pkg::CTL_IMP_MSB:perf_mon_pkg::CTL_IMP_LSB] =
            perf_mon_pkg::IMPLEMENTER_CODE;
        v[perf_mon_pkg::CTL_N_MSB:perf_mon_pkg::CTL_N_LSB] = N_FIELD;
        v[perf_mon_pkg::CTL_LP] = lp;
        v[perf_mon_pkg::CTL_ONE] = 1'b1;
        v[perf_mon_pkg::CTL_DP] = dp;
        v[perf_mon_pkg::CTL_E] = e;
        // clear bits are write-only and stay zero here
        return v;
    endfunction

    // access decision for a machine-info read: kind and level
    function automatic logic [3:0] mi_access(
        input logic [1:0] el,
        input perf_mon_pkg::trap_cfg_s c
    );
        logic [3:0] r;
        r = {perf_mon_pkg::RSP_DATA, el};
        unique case (el)
            perf_mon_pkg::EL_USER:
            begin
                r = {perf_mon_pkg::RSP_UNDEF, el};
            end
            perf_mon_pkg::EL_KERNEL:
            begin
                // fine-grained trap outranks the coarse traps
                if (c.el2_enabled && c.fine_grain_trap_enable && c.fine_grain_read_trap)
                begin
                    r = {perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_HYP};
                end
                else if (c.el2_enabled && c.hyp_perf_trap)
                begin
                    r = {perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_HYP};
                end
                else if (c.monitor_perf_trap)
                begin
                    r = {perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_MON};
                end
            end
            perf_mon_pkg::EL_HYP:
            begin
                if (c.monitor_perf_trap)
                begin
                    r = {perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_MON};
                end
            end
            perf_mon_pkg::EL_MON:
            begin
                r = {perf_mon_pkg::RSP_DATA, el};
            end
        endcase
        return r;
    endfunction

    // -------------------------------------------------------
    // partition limit and counter scope
    // -------------------------------------------------------
    // limit follows the partition field whenever the level exists,
    // enabled or not, so the E and LP bits never reach upper counters
    assign partition_limit = trap_cfg.el2_impl ?
        trap_cfg.hyp_counter_partition : N_FIELD;
    // only user and kernel clears are limited
    assign restrict_clear = (req.el == perf_mon_pkg::EL_USER ||
        req.el == perf_mon_pkg::EL_KERNEL) && trap_cfg.el2_enabled &&
        (partition_limit < N_FIELD);

    counter_scope #(
        .NUM_CTRS(NUM_CTRS)
    ) u_scope (
        .partition_limit(partition_limit),
        .global_enable(s_r.e),
        .long_counter_select(s_r.lp),
        .hyp_long_counter_select(hyp_long_counter_select),
        .upper_global_enable(upper_global_enable),
        .restrict_clear(restrict_clear),
        .counter_enable_set(counter_enable_set),
        .count_en(scope_en),
        .long_mode(scope_long),
        .clear_mask(scope_clr)
    );

    // -------------------------------------------------------
    // next state
    // -------------------------------------------------------
    // each request is answered on the following edge
    always_comb
    begin
        logic [3:0] acc;
        acc = 4'h0;
        s_nxt = s_r;
        s_nxt.rsp.valid = req.valid;
        s_nxt.rsp.kind = perf_mon_pkg::RSP_DATA;
        s_nxt.rsp.target_el = req.el;
        s_nxt.rsp.syndrome = 6'h00;
        s_nxt.rsp.rdata = 64'h0000_0000_0000_0000;
        s_nxt.evt_clr = '0;
        s_nxt.cyc_clr = 1'b0;
        if (req.valid && req.sel == perf_mon_pkg::SEL_MACHINE_INFO)
        begin
            if (req.write)
            begin
                // read-only register: a write is undefined
                s_nxt.rsp.kind = perf_mon_pkg::RSP_UNDEF;
            end
            else
            begin
                acc = mi_access(req.el, trap_cfg);
                s_nxt.rsp.kind = perf_mon_pkg::rsp_kind_e'(acc[3:2]);
                s_nxt.rsp.target_el = acc[1:0];
                if (s_nxt.rsp.kind == perf_mon_pkg::RSP_DATA)
                begin
                    s_nxt.rsp.rdata[perf_mon_pkg::STALL_SLOT_WIDTH_MSB:perf_mon_pkg::STALL_SLOT_WIDTH_LSB] =
                        perf_mon_pkg::STALL_SLOT_WIDTH;
                end
                if (s_nxt.rsp.kind == perf_mon_pkg::RSP_TRAP)
                begin
                    s_nxt.rsp.syndrome = perf_mon_pkg::SYN_SYSREG;
                end
            end
        end
        else if (req.valid && req.write)
        begin
            s_nxt.lp = req.wdata[perf_mon_pkg::CTL_LP];
            s_nxt.dp = req.wdata[perf_mon_pkg::CTL_DP];
            s_nxt.e = req.wdata[perf_mon_pkg::CTL_E];
            // pulses zero whole counters; overflow flags live elsewhere
            s_nxt.cyc_clr = req.wdata[perf_mon_pkg::CTL_C];
            if (req.wdata[perf_mon_pkg::CTL_P])
            begin
                s_nxt.evt_clr = scope_clr;
            end
        end
        else if (req.valid)
        begin
            s_nxt.rsp.rdata = ctl_image(s_r.lp, s_r.dp, s_r.e);
        end
        s_nxt.evt_en = scope_en;
        s_nxt.evt_long = scope_long;
        // cycle counter gated by enable and prohibited-stop
        s_nxt.cyc_en = s_r.e && cycle_enable_set &&
            !(s_r.dp && counting_prohibited);
    end

    // -------------------------------------------------------
    // registers
    // -------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.lp <= perf_mon_pkg::RST_LP;
            s_r.dp <= perf_mon_pkg::RST_DP;
            s_r.e <= perf_mon_pkg::RST_E;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign rsp = s_r.rsp;
    assign evt_count_en = s_r.evt_en;
    assign evt_long_mode = s_r.evt_long;
    assign evt_clear = s_r.evt_clr;
    assign cyc_count_en = s_r.cyc_en;
    assign cyc_clear = s_r.cyc_clr;

    // -------------------------------------------------------
    // assertions
    // -------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic mi_rd;
    logic ctl_rd;
    assign mi_rd = req.valid && !req.write &&
        req.sel == perf_mon_pkg::SEL_MACHINE_INFO;
    assign ctl_rd = req.valid && !req.write &&
        req.sel == perf_mon_pkg::SEL_CONTROL;

    AST_STALL_SLOT_WIDTH_VALUE: assert property (
        mi_rd && req.el == perf_mon_pkg::EL_MON |=>
        rsp.valid && rsp.rdata == 64'h0000_0000_0000_0008)
        else $error("machine info value wrong");

    AST_USER_UNDEF: assert property (
        mi_rd && req.el == perf_mon_pkg::EL_USER |=>
        rsp.kind == perf_mon_pkg::RSP_UNDEF && rsp.rdata == 64'h0000_0000_0000_0000)
        else $error("user read not undefined");

    AST_FINE_TRAP: assert property (
        mi_rd && req.el == perf_mon_pkg::EL_KERNEL && trap_cfg.el2_enabled &&
        trap_cfg.fine_grain_trap_enable && trap_cfg.fine_grain_read_trap |=>
        rsp.kind == perf_mon_pkg::RSP_TRAP && rsp.target_el == perf_mon_pkg::EL_HYP &&
        rsp.syndrome == 6'h18)
        else $error("fine-grained trap missed");

    AST_KERNEL_MON: assert property (
        mi_rd && req.el == perf_mon_pkg::EL_KERNEL && !trap_cfg.el2_enabled &&
        trap_cfg.monitor_perf_trap |=>
        rsp.kind == perf_mon_pkg::RSP_TRAP && rsp.target_el == perf_mon_pkg::EL_MON)
        else $error("kernel monitor trap missed");

    AST_HYP_MON: assert property (
        mi_rd && req.el == perf_mon_pkg::EL_HYP |=>
        (rsp.kind == perf_mon_pkg::RSP_TRAP) == $past(trap_cfg.monitor_perf_trap))
        else $error("hypervisor trap wrong");

    AST_CTL_IMAGE: assert property (
        ctl_rd |=> rsp.rdata[63:16] == 48'h0000_0000_0000 &&
        rsp.rdata[15:11] == N_FIELD && rsp.rdata[6] == 1'b1)
        else $error("control image wrong");

    AST_CLEAR_RAZ: assert property (
        ctl_rd |=> rsp.rdata[2:1] == 2'b00 && rsp.rdata[4:3] == 2'b00)
        else $error("clear bits not zero");

    AST_CYC_CLEAR: assert property (
        req.valid && req.write && req.sel == perf_mon_pkg::SEL_CONTROL &&
        req.wdata[2] ##1 !(req.valid && req.write && req.sel == perf_mon_pkg::SEL_CONTROL)
        |-> cyc_clear ##1 !cyc_clear)
        else $error("cycle clear pulse wrong");

    AST_CLR_LIMITED: assert property (
        req.valid && req.write && req.sel == perf_mon_pkg::SEL_CONTROL &&
        req.wdata[1] && restrict_clear |=>
        (evt_clear >> $past(partition_limit)) == '0)
        else $error("upper counters cleared");

    AST_CLR_ALL: assert property (
        req.valid && req.write && req.sel == perf_mon_pkg::SEL_CONTROL &&
        req.wdata[1] && req.el[1] |=> &evt_clear)
        else $error("privileged clear incomplete");

    AST_ENABLE_OFF: assert property (
        !s_r.e |=> !cyc_count_en)
        else $error("cycle counts while disabled");

    AST_DP_STOP: assert property (
        s_r.dp && counting_prohibited |=> !cyc_count_en)
        else $error("cycle counts while prohibited");

    COV_TRAP_HYP: cover property (
        mi_rd && req.el == perf_mon_pkg::EL_KERNEL ##1
        rsp.target_el == perf_mon_pkg::EL_HYP);
    COV_EVT_CLEAR: cover property (evt_clear != '0);
    COV_CYC_RUN: cover property (cyc_count_en [*3]);

endmodule // perf_monitor_control_regs

`default_nettype wire

// *** tb/perf_monitor_control_regs_tb.sv ***
/*
 * self-checking bench for the performance-monitor identification
 * and control registers: trap decode, control image, clears, enables.
 * assumes the design package is compiled first; one clock, no partner.
 */
`timescale 1ns/1ps
`default_nettype none

module perf_monitor_control_regs_tb;
    localparam int NUM = 6;
    logic ref_clk;
    logic rst_n;
    perf_mon_pkg::sysreg_req_s req;
    perf_mon_pkg::trap_cfg_s cfg;
    logic hyp_long;
    logic upper;
    logic [NUM-1:0] ces;
    logic ces_cyc;
    logic prohib;
    perf_mon_pkg::sysreg_rsp_s rsp;
    logic [NUM-1:0] evt_count_en;
    logic [NUM-1:0] evt_long_mode;
    logic [NUM-1:0] evt_clear;
    logic cyc_count_en;
    logic cyc_clear;
    perf_mon_pkg::sysreg_rsp_s exp_q[$];
    perf_mon_pkg::trap_cfg_s tc;
    int failures;
    int check_count;

    perf_monitor_control_regs #(.NUM_CTRS(NUM)) i_perf_monitor_control_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .trap_cfg(cfg),
        .hyp_long_counter_select(hyp_long), .upper_global_enable(upper),
        .counter_enable_set(ces), .cycle_enable_set(ces_cyc), .counting_prohibited(prohib),
        .rsp(rsp), .evt_count_en(evt_count_en), .evt_long_mode(evt_long_mode),
        .evt_clear(evt_clear), .cyc_count_en(cyc_count_en), .cyc_clear(cyc_clear)
    );

    // -------------------------------------------------------
    // clock and shared helpers
    // -------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic perf_mon_pkg::sysreg_rsp_s mk(perf_mon_pkg::rsp_kind_e k, logic [1:0] tel,
                                                     logic [63:0] rd);
        mk = '{valid: 1'b1, kind: k, target_el: tel,
               syndrome: (k == perf_mon_pkg::RSP_TRAP) ? perf_mon_pkg::SYN_SYSREG : 6'h00, rdata: rd};
    endfunction

    // control image: bit 6 fixed high, count field from the build size
    function automatic logic [63:0] img(logic lp, logic dp, logic e);
        img = 64'h0000_0000_0000_0040 | (64'(NUM) << 11) | (64'(lp) << 7) | (64'(dp) << 5) | 64'(e);
    endfunction

    // expected answer to a machine-info read, from the level and trap bits
    function automatic perf_mon_pkg::sysreg_rsp_s mi_exp(logic [1:0] el, perf_mon_pkg::trap_cfg_s c);
        if (el == perf_mon_pkg::EL_USER)
            return mk(perf_mon_pkg::RSP_UNDEF, el, 64'h0000_0000_0000_0000);
        if (el == perf_mon_pkg::EL_KERNEL && c.el2_enabled &&
            ((c.fine_grain_trap_enable && c.fine_grain_read_trap) || c.hyp_perf_trap))
            return mk(perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_HYP, 64'h0000_0000_0000_0000);
        if (el != perf_mon_pkg::EL_MON && c.monitor_perf_trap)
            return mk(perf_mon_pkg::RSP_TRAP, perf_mon_pkg::EL_MON, 64'h0000_0000_0000_0000);
        return mk(perf_mon_pkg::RSP_DATA, el, 64'(perf_mon_pkg::STALL_SLOT_WIDTH));
    endfunction

    // send presents a request in the current step; the caller owns the edge
    task automatic send(input logic wr, input logic sel, input logic [1:0] el, input logic [63:0] wd,
                        input perf_mon_pkg::sysreg_rsp_s exp);
        req <= '{valid: 1'b1, write: wr, sel: sel, el: el, wdata: wd};
        exp_q.push_back(exp);
    endtask

    task automatic idle;
        @(posedge ref_clk);
        req.valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd_ctl(input logic [1:0] el, input logic lp, input logic dp, input logic e);
        @(posedge ref_clk);
        send(1'b0, perf_mon_pkg::SEL_CONTROL, el, 64'h0000_0000_0000_0000,
             mk(perf_mon_pkg::RSP_DATA, el, img(lp, dp, e)));
        idle;
    endtask

    // write control, then look at the clear pulses in the answer cycle
    task automatic wr_clr(input logic [1:0] el, input logic [63:0] wd, input logic [NUM-1:0] x_evt,
                          input logic x_cyc);
        @(posedge ref_clk);
        send(1'b1, perf_mon_pkg::SEL_CONTROL, el, wd, mk(perf_mon_pkg::RSP_DATA, el, 64'h0000_0000_0000_0000));
        idle;
        check(80'(evt_clear), 80'(x_evt), "event clear");
        check(80'(cyc_clear), 80'(x_cyc), "cycle clear");
    endtask

    task automatic check_en(input logic e, input logic lp, input logic dp);
        int lim;
        logic [NUM-1:0] en_x;
        logic [NUM-1:0] lm_x;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        lim = cfg.el2_impl ? int'(cfg.hyp_counter_partition) : NUM;
        for (int i = 0; i < NUM; i++)
        begin
            en_x[i] = (i < lim) ? (e & ces[i]) : (upper & ces[i]);
            lm_x[i] = (i < lim) ? lp : hyp_long;
        end
        check(80'(evt_count_en), 80'(en_x), "count enable");
        check(80'(evt_long_mode), 80'(lm_x), "long mode");
        check(80'(cyc_count_en), 80'(ces_cyc & e & ~(dp & prohib)), "cycle enable");
    endtask

    task automatic tally_and_finish;
        if (exp_q.size() != 0)
        begin
            failures++;
            $display("BAD t=%0t answers missing", $time);
        end
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // -------------------------------------------------------
    // answer watcher: oldest note against every valid answer
    // -------------------------------------------------------
    always @(negedge ref_clk)
    begin
        if (rst_n === 1'b1 && rsp.valid !== 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                failures++;
                $display("BAD t=%0t unexpected answer", $time);
            end
            else
                check(80'(rsp), 80'(exp_q.pop_front()), "answer");
        end
    end

    // hang guard: the tests need about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    // -------------------------------------------------------
    // main sequence
    // -------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        req = '0;
        cfg = '0;
        hyp_long = 1'b0;
        upper = 1'b0;
        ces = '0;
        ces_cyc = 1'b0;
        prohib = 1'b0;
        failures = 0;
        check_count = 0;
        void'($urandom(11361));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_ctl(perf_mon_pkg::EL_MON, 1'b0, 1'b0, 1'b0);
        $display("reset image test done");
        // back-to-back machine-info reads under random trap settings
        for (int n = 0; n < 40; n++)
        begin
            tc = perf_mon_pkg::trap_cfg_s'($urandom);
            @(posedge ref_clk);
            cfg <= tc;
            send(1'b0, perf_mon_pkg::SEL_MACHINE_INFO, 2'(n), 64'h0000_0000_0000_0000, mi_exp(2'(n), tc));
        end
        // directed fine-grained trap, in case the random draws never line up all three bits
        tc = '{el2_impl: 1'b1, el2_enabled: 1'b1, fine_grain_trap_enable: 1'b1, fine_grain_read_trap: 1'b1,
               default: 1'b0};
        @(posedge ref_clk);
        cfg <= tc;
        send(1'b0, perf_mon_pkg::SEL_MACHINE_INFO, perf_mon_pkg::EL_KERNEL, 64'h0000_0000_0000_0000,
             mi_exp(perf_mon_pkg::EL_KERNEL, tc));
        @(posedge ref_clk);
        send(1'b1, perf_mon_pkg::SEL_MACHINE_INFO, perf_mon_pkg::EL_MON, '1,
             mk(perf_mon_pkg::RSP_UNDEF, perf_mon_pkg::EL_MON, 64'h0000_0000_0000_0000));
        idle;
        rd_ctl(perf_mon_pkg::EL_MON, 1'b0, 1'b0, 1'b0);
        $display("machine info test done");
        // clears: partition below count, by level
        @(posedge ref_clk);
        cfg <= '{el2_impl: 1'b1, el2_enabled: 1'b1, hyp_counter_partition: 5'h03, default: 1'b0};
        wr_clr(perf_mon_pkg::EL_HYP, '1, '1, 1'b1);
        rd_ctl(perf_mon_pkg::EL_HYP, 1'b1, 1'b1, 1'b1);
        // mid-run reset must drop the control bits back to their reset values
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_ctl(perf_mon_pkg::EL_HYP, perf_mon_pkg::RST_LP, perf_mon_pkg::RST_DP, perf_mon_pkg::RST_E);
        wr_clr(perf_mon_pkg::EL_KERNEL, 64'h0000_0000_0000_0002, 6'h07, 1'b0);
        wr_clr(perf_mon_pkg::EL_USER, 64'h0000_0000_0000_0004, 6'h00, 1'b1);
        wr_clr(perf_mon_pkg::EL_USER, 64'h0000_0000_0000_0000, 6'h00, 1'b0);
        @(posedge ref_clk);
        cfg.el2_enabled <= 1'b0;
        wr_clr(perf_mon_pkg::EL_USER, 64'h0000_0000_0000_0002, '1, 1'b0);
        $display("clear test done");
        // enables and long mode against the partition limit
        @(posedge ref_clk);
        ces <= NUM'($urandom);
        upper <= 1'($urandom);
        hyp_long <= 1'($urandom);
        ces_cyc <= 1'b1;
        wr_clr(perf_mon_pkg::EL_MON, 64'h0000_0000_0000_0081, 6'h00, 1'b0);
        check_en(1'b1, 1'b1, 1'b0);
        wr_clr(perf_mon_pkg::EL_MON, 64'h0000_0000_0000_0021, 6'h00, 1'b0);
        @(posedge ref_clk);
        prohib <= 1'b1;
        check_en(1'b1, 1'b0, 1'b1);
        @(posedge ref_clk);
        prohib <= 1'b0;
        cfg.el2_impl <= 1'b0;
        check_en(1'b1, 1'b0, 1'b1);
        wr_clr(perf_mon_pkg::EL_MON, 64'h0000_0000_0000_0000, 6'h00, 1'b0);
        check_en(1'b0, 1'b0, 1'b0);
        rd_ctl(perf_mon_pkg::EL_USER, 1'b0, 1'b0, 1'b0);
        $display("enable test done");
        repeat (2) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule // perf_monitor_control_regs_tb

`default_nettype wire
